/* sim/pps_host_model.sv */
// Host processor model that drives the hold input.
`timescale 1ns/1ns
module pps_host_model (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic go_i,
    input wire pps_pkg::pps_power_out_t power_i,
    output logic en_hold_o
);
    import pps_pkg::*;
    // Hold is claimed only once out of reset, so a short key tap lets the core fall back off.
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            en_hold_o <= 1'b0;
        else if (!go_i || !power_i.key_event_n)
            en_hold_o <= 1'b0;
        else if (power_i.reset_n)
            en_hold_o <= 1'b1;
    end
endmodule

/* sim/pps_seq_assertions.sv */
// Checker of the power sequencer outputs.
`timescale 1ns/1ns
module pps_seq_assertions #(
    parameter int unsigned RESET_CYCLES = 20
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic en_key_n_i,
    input wire logic en_hold_i,
    input wire logic en_test_i,
    input wire logic charger_input_ok_i,
    input wire logic buck_pg_i,
    input wire logic ldo1_pg_i,
    input wire logic [3:0] ldo_enable_pin_i,
    input wire logic charger_enable_n_i,
    input wire pps_pkg::pps_power_out_t power_o
);
    import pps_pkg::*;
    // Wide enough for the full-length reset delay, so the count never wraps before release.
    logic [31:0] pg_cnt;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    sequence idle_s;
        en_key_n_i && !en_hold_i && !en_test_i && !charger_input_ok_i;
    endsequence
    // The good-LDO run length pins the reset delay without unrolling a long repetition.
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            pg_cnt <= 32'h0;
        else
            pg_cnt <= (ldo1_pg_i && power_o.ldo1_en) ? pg_cnt + 32'h1 : 32'h0;
    end
    ldo_gate_a: assert property (!power_o.buck_en |-> power_o.ldo_out_en == 4'h0)
        else $error("ldo on while off");
    ldo_follow_a: assert property (power_o.buck_en && $past(power_o.buck_en) |->
        power_o.ldo_out_en == $past(ldo_enable_pin_i)) else $error("ldo not following pin");
    ldo1_order_a: assert property ($rose(power_o.ldo1_en) |->
        power_o.buck_en && $past(buck_pg_i, 2)) else $error("ldo1 before buck good");
    rst_early_a: assert property (!power_o.ldo1_en |-> !power_o.reset_n)
        else $error("reset released early");
    rst_timer_a: assert property ($rose(power_o.reset_n) |->
        pg_cnt > RESET_CYCLES && pg_cnt < RESET_CYCLES + 6) else $error("reset delay wrong");
    shut_off_a: assert property (idle_s [*4] |=> !power_o.buck_en &&
        !power_o.ldo1_en && power_o.ldo_out_en == 4'h0 && power_o.discharge == 2'h3)
        else $error("not off after idle");
    chg_keep_a: assert property ($past(charger_input_ok_i) && $past(power_o.buck_en) |->
        power_o.buck_en) else $error("off with charger");
    chg_gate_a: assert property (power_o.charge_allow |->
        $past(charger_input_ok_i) && !$past(charger_enable_n_i)) else $error("charge not gated");
    key_event_a: assert property ($fell(power_o.key_event_n) |-> !$past(en_key_n_i, 3))
        else $error("key event without press");
endmodule
bind pps_sequencer pps_seq_assertions #(.RESET_CYCLES(RESET_CYCLES)) i_pps_seq_assertions (
    .clk_sys_i, .rst_b_i, .en_key_n_i, .en_hold_i, .en_test_i, .charger_input_ok_i, .buck_pg_i,
    .ldo1_pg_i, .ldo_enable_pin_i, .charger_enable_n_i, .power_o);

/* sim/pps_sequencer_bench.sv */
// Self-checking bench of the power sequencer.
`timescale 1ns/1ns
module pps_sequencer_bench;
    import pps_pkg::*;
    localparam int unsigned RC = 20;
    logic clk_sys_i = 1'b0, rst_b_i = 1'b0, en_key_n_i = 1'b1, en_test_i = 1'b0;
    logic charger_input_ok_i = 1'b0, buck_pg_i = 1'b0, ldo1_pg_i = 1'b0, use_battery_path_i = 1'b0;
    logic charger_enable_n_i = 1'b0, battery_present_i = 1'b0, battery_below_min_i = 1'b0;
    logic go = 1'b0, en_hold_i, err;
    logic [3:0] ldo_enable_pin_i = 4'h5;
    logic [31:0] rd;
    pps_apb_req_t apb_req_i = '0;
    pps_apb_rsp_t apb_rsp_o;
    pps_power_out_t pw;
    int error_cnt = 0, n_compared = 0, cyc = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    pps_sequencer #(.RESET_CYCLES(RC)) i_pps_sequencer (.clk_sys_i, .rst_b_i, .en_key_n_i,
        .en_hold_i, .en_test_i, .charger_input_ok_i, .buck_pg_i, .ldo1_pg_i, .ldo_enable_pin_i,
        .use_battery_path_i, .charger_enable_n_i, .battery_present_i, .battery_below_min_i,
        .apb_req_i, .apb_rsp_o, .power_o(pw));
    pps_host_model i_pps_host_model (.clk_sys_i, .rst_b_i, .go_i(go), .power_i(pw),
        .en_hold_o(en_hold_i));
    // Regulators report good one cycle after enable, the fastest ramp possible.
    always @(posedge clk_sys_i)
    begin
        buck_pg_i <= pw.buck_en;
        ldo1_pg_i <= pw.ldo1_en;
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            error_cnt++;
            test_done;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wait_rst;
        for (int i = 0; i < 200 && pw.reset_n !== 1'b1; i++)
            tick(1);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        apb_req_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        tick(1);
        apb_req_i.penable <= 1'b1;
        // Only the bench cycle limit ends a transfer that never completes.
        do
        begin
            tick(1);
        end
        while (apb_rsp_o.pready !== 1'b1);
        rd = apb_rsp_o.prdata;
        err = apb_rsp_o.pslverr;
        apb_req_i <= '0;
        tick(1);
    endtask
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        tick(5);
        chk("reset outputs", 32'h01c4, {16'h0, pw});
        rst_b_i <= 1'b1;
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk("ctrl reset", CTRL_RESET, rd);
        apb(1'b1, STATUS_ADDR, 32'hffff_ffff);
        chk("status write", 32'h0, {31'h0, err});
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk("status off", 32'h10, rd);
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        $display("apb test done");
        en_key_n_i <= 1'b0;
        go <= 1'b1;
        tick(4);
        chk("ramp", 32'h25, {26'h0, pw.buck_en, pw.ldo1_en, pw.ldo_out_en});
        wait_rst;
        chk("reset out", 32'h1, {31'h0, pw.reset_n});
        tick(3);
        en_key_n_i <= 1'b1;
        tick(6);
        chk("hold keeps", 32'h1, {31'h0, pw.buck_en});
        en_key_n_i <= 1'b0;
        tick(5);
        chk("key event", 32'h2, {30'h0, pw.buck_en, pw.key_event_n});
        go <= 1'b0;
        en_key_n_i <= 1'b1;
        tick(5);
        chk("power down", 32'h7, {23'h0, pw.buck_en, pw.ldo1_en, pw.ldo_out_en,
            pw.discharge, pw.key_event_n});
        en_key_n_i <= 1'b0;
        tick(8);
        en_key_n_i <= 1'b1;
        tick(5);
        chk("tap off", 32'h0, {27'h0, pw.buck_en, pw.ldo_out_en});
        $display("key test done");
        battery_present_i <= 1'b1;
        battery_below_min_i <= 1'b1;
        charger_input_ok_i <= 1'b1;
        wait_rst;
        chk("charger on", 32'h69, {25'h0, pw.buck_en, pw.chg_path, pw.bat_path,
            pw.charge_allow, pw.charger_sleep, pw.charge_mode});
        battery_below_min_i <= 1'b0;
        use_battery_path_i <= 1'b1;
        tick(2);
        chk("battery select", 32'h6, {29'h0, pw.bat_path, pw.charge_mode});
        use_battery_path_i <= 1'b0;
        charger_enable_n_i <= 1'b1;
        apb(1'b1, CTRL_ADDR, 32'h1);
        tick(1);
        chk("forced battery", 32'h2, {30'h0, pw.bat_path, pw.charge_allow});
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk("ctrl readback", 32'h1, rd);
        apb(1'b1, CTRL_ADDR, 32'h0);
        tick(4);
        chk("charger keeps", 32'h2, {30'h0, pw.buck_en, pw.bat_path});
        charger_input_ok_i <= 1'b0;
        tick(3);
        chk("charger gone", 32'h1, {30'h0, pw.buck_en, pw.charger_sleep});
        en_test_i <= 1'b1;
        wait_rst;
        chk("test start", 32'h3, {30'h0, pw.buck_en, pw.bat_path});
        en_test_i <= 1'b0;
        tick(5);
        chk("test off", 32'h0, {31'h0, pw.buck_en});
        $display("charger and test pin test done");
        test_done;
    end
endmodule

/* verilog/pps_pkg.sv */
// Constants, types and field layouts shared by the power sequencer.
package pps_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned RESET_TIME_MS = 65;
    localparam int unsigned RESET_CYCLES = RESET_TIME_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 22;
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam int CTRL_FORCE_BAT_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int NUM_SYNC = 5;
    localparam int SYNC_KEY_N = 0;
    localparam int SYNC_HOLD = 1;
    localparam int SYNC_TEST = 2;
    localparam int SYNC_BUCK_PG = 3;
    localparam int SYNC_LDO1_PG = 4;

    typedef enum logic [2:0] {
        PPS_OFF,
        PPS_BUCK_RAMP,
        PPS_LDO1_RAMP,
        PPS_RST_WAIT,
        PPS_ON
    } pps_state_t;

    typedef enum logic [1:0] {
        PPS_CHG_IDLE,
        PPS_CHG_PRECOND,
        PPS_CHG_FAST
    } pps_chg_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pps_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pps_apb_rsp_t;

    typedef struct packed {
        logic buck_en;
        logic ldo1_en;
        logic [3:0] ldo_out_en;
        logic reset_n;
        logic key_event_n;
        logic [1:0] discharge;
        logic chg_path;
        logic bat_path;
        logic charge_allow;
        logic charger_sleep;
        pps_chg_mode_t charge_mode;
    } pps_power_out_t;
endpackage

/* verilog/pps_sequencer.sv */
// Power-up, power-down, supply path and charger gating sequencer with APB registers.
`timescale 1ns/1ns
module pps_sequencer #(
    parameter int unsigned RESET_CYCLES = pps_pkg::RESET_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic en_key_n_i,
    input wire logic en_hold_i,
    input wire logic en_test_i,
    input wire logic charger_input_ok_i,
    input wire logic buck_pg_i,
    input wire logic ldo1_pg_i,
    input wire logic [3:0] ldo_enable_pin_i,
    input wire logic use_battery_path_i,
    input wire logic charger_enable_n_i,
    input wire logic battery_present_i,
    input wire logic battery_below_min_i,
    input wire pps_pkg::pps_apb_req_t apb_req_i,
    output pps_pkg::pps_apb_rsp_t apb_rsp_o,
    output pps_pkg::pps_power_out_t power_o
);
    import pps_pkg::*;

    typedef struct packed {
        logic [NUM_SYNC-1:0] sync1;
        logic [NUM_SYNC-1:0] sync2;
        pps_state_t state;
        logic [CNT_W-1:0] count;
        logic key_released;
        logic key_prev_down;
        logic force_bat;
        pps_apb_rsp_t rsp;
        pps_power_out_t pwr;
    } pps_regs_t;

    pps_regs_t r;
    pps_regs_t next_r;

    logic [NUM_SYNC-1:0] raw_in;
    logic key_down;
    logic hold_on;
    logic test_on;
    logic buck_good;
    logic ldo1_good;
    logic trigger;
    logic keep_on;
    logic core_on;
    logic bat_sel;

    function automatic logic [31:0] pps_read(input logic [7:0] addr, input pps_regs_t s);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (addr == CTRL_ADDR)
        begin
            d[CTRL_FORCE_BAT_BIT] = s.force_bat;
        end
        else if (addr == STATUS_ADDR)
        begin
            d[2:0] = s.state;
            d[3] = s.pwr.reset_n;
            d[4] = s.pwr.key_event_n;
            d[5] = s.pwr.chg_path;
            d[6] = s.pwr.bat_path;
            d[7] = s.pwr.charge_allow;
            d[9:8] = s.pwr.charge_mode;
            d[13:10] = s.pwr.ldo_out_en;
        end
        return d;
    endfunction

    function automatic logic pps_mapped(input logic [7:0] addr);
        return (addr == CTRL_ADDR) || (addr == STATUS_ADDR);
    endfunction

    assign raw_in = {ldo1_pg_i, buck_pg_i, en_test_i, en_hold_i, ~en_key_n_i};

    always_comb
    begin
        next_r = r;
        // Key, hold, test and power-good inputs are double-registered; the charger and battery inputs are used directly.
        next_r.sync1 = raw_in;
        next_r.sync2 = r.sync1;
        key_down = r.sync2[SYNC_KEY_N];
        hold_on = r.sync2[SYNC_HOLD];
        test_on = r.sync2[SYNC_TEST];
        buck_good = r.sync2[SYNC_BUCK_PG];
        ldo1_good = r.sync2[SYNC_LDO1_PG];

        trigger = key_down || charger_input_ok_i || test_on;
        // A valid charger or test pin keeps the core alive; otherwise key OR hold.
        // Charger presence vetoes every power-down request.
        // Key released without hold, test pin or charger drops keep_on and shuts down.
        keep_on = key_down || hold_on || test_on || charger_input_ok_i;

        case (r.state)
            PPS_OFF:
            begin
                if (trigger)
                begin
                    next_r.state = PPS_BUCK_RAMP;
                end
            end
            PPS_BUCK_RAMP:
            begin
                if (buck_good)
                begin
                    next_r.state = PPS_LDO1_RAMP;
                end
            end
            PPS_LDO1_RAMP:
            begin
                if (ldo1_good)
                begin
                    next_r.state = PPS_RST_WAIT;
                    next_r.count = '0;
                end
            end
            PPS_RST_WAIT:
            begin
                if (r.count == CNT_W'(RESET_CYCLES - 1))
                begin
                    next_r.state = PPS_ON;
                end
                else
                begin
                    next_r.count = r.count + CNT_W'(1);
                end
            end
            PPS_ON:
            begin
                next_r.state = PPS_ON;
            end
            default:
            begin
                next_r.state = PPS_OFF;
            end
        endcase
        if (r.state != PPS_OFF && !keep_on)
        begin
            next_r.state = PPS_OFF;
        end

        // The first press counts only once it has been let go; the next press is the event.
        next_r.key_prev_down = key_down;
        if (next_r.state == PPS_OFF)
        begin
            next_r.key_released = 1'b0;
        end
        else if (!key_down)
        begin
            next_r.key_released = 1'b1;
        end
        if (r.state != PPS_OFF && r.key_released && key_down && !r.key_prev_down)
        begin
            next_r.pwr.key_event_n = 1'b0;
        end
        else if (!key_down || next_r.state == PPS_OFF)
        begin
            next_r.pwr.key_event_n = 1'b1;
        end

        core_on = next_r.state != PPS_OFF;
        next_r.pwr.buck_en = core_on;
        next_r.pwr.ldo1_en = core_on && next_r.state != PPS_BUCK_RAMP;
        // Auxiliary LDOs share the core enable so they drop in the same edge.
        next_r.pwr.ldo_out_en = core_on ? ldo_enable_pin_i : 4'h0;
        next_r.pwr.reset_n = next_r.state == PPS_ON;
        next_r.pwr.discharge = core_on ? 2'h0 : 2'h3;

        bat_sel = use_battery_path_i || r.force_bat;
        next_r.pwr.chg_path = charger_input_ok_i && !bat_sel && core_on;
        next_r.pwr.bat_path = core_on && (bat_sel || !charger_input_ok_i);
        next_r.pwr.charge_allow = charger_input_ok_i && !charger_enable_n_i;
        next_r.pwr.charger_sleep = !charger_input_ok_i;
        // Mode is chosen from the battery state on the same edge that charging is let start.
        if (next_r.pwr.charge_allow && battery_present_i)
        begin
            next_r.pwr.charge_mode = battery_below_min_i ? PPS_CHG_PRECOND : PPS_CHG_FAST;
        end
        else
        begin
            next_r.pwr.charge_mode = PPS_CHG_IDLE;
        end

        // APB slave: one wait state, ready and data come from flip-flops.
        next_r.rsp.pready = 1'b0;
        next_r.rsp.pslverr = 1'b0;
        if (apb_req_i.psel && apb_req_i.penable && !r.rsp.pready)
        begin
            next_r.rsp.pready = 1'b1;
            next_r.rsp.pslverr = !pps_mapped(apb_req_i.paddr);
            next_r.rsp.prdata = apb_req_i.pwrite ? 32'h0000_0000 : pps_read(apb_req_i.paddr, r);
        end
        // The write lands on the edge where the master sees pready high.
        if (apb_req_i.psel && apb_req_i.penable && r.rsp.pready && apb_req_i.pwrite)
        begin
            if (apb_req_i.paddr == CTRL_ADDR)
            begin
                next_r.force_bat = apb_req_i.pwdata[CTRL_FORCE_BAT_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            r <= '{
                sync1: '0,
                sync2: '0,
                state: PPS_OFF,
                count: '0,
                key_released: 1'b0,
                key_prev_down: 1'b0,
                force_bat: CTRL_RESET[CTRL_FORCE_BAT_BIT],
                rsp: '0,
                pwr: '{
                    buck_en: 1'b0,
                    ldo1_en: 1'b0,
                    ldo_out_en: 4'h0,
                    reset_n: 1'b0,
                    key_event_n: 1'b1,
                    discharge: 2'h3,
                    chg_path: 1'b0,
                    bat_path: 1'b0,
                    charge_allow: 1'b0,
                    charger_sleep: 1'b1,
                    charge_mode: PPS_CHG_IDLE
                }
            };
        end
        else
        begin
            r <= next_r;
        end
    end

    assign apb_rsp_o = r.rsp;
    assign power_o = r.pwr;
endmodule
